// file: rtl/cpuag_pkg.sv
// Package of constants and types for the CPU address generation block
`default_nettype none
package cpuag_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int RF_IDX_W = 5;
   // ------------------------------------------------------------
   // Byte register codes and pair codes
   // ------------------------------------------------------------
   localparam logic [2:0] CODE_X = 3'h0;
   localparam logic [2:0] CODE_A = 3'h1;
   localparam logic [2:0] CODE_C = 3'h2;
   localparam logic [2:0] CODE_B = 3'h3;
   localparam logic [2:0] CODE_E = 3'h4;
   localparam logic [2:0] CODE_D = 3'h5;
   localparam logic [2:0] CODE_L = 3'h6;
   localparam logic [2:0] CODE_H = 3'h7;
   localparam logic [1:0] PAIR_ACC = 2'h0;
   localparam logic [1:0] PAIR_BC = 2'h1;
   localparam logic [1:0] PAIR_SECOND = 2'h2;
   localparam logic [1:0] PAIR_BASE = 2'h3;
   // ------------------------------------------------------------
   // Address map constants
   // ------------------------------------------------------------
   localparam logic [6:0] SHORT_TOP_BITS = 7'h7F;
   localparam logic [7:0] SHORT_SPLIT = 8'h20;
   localparam logic [7:0] SFR_PAGE = 8'hFF;
   localparam logic [7:0] SFR_HOLE_LO = 8'hD0;
   localparam logic [7:0] SFR_HOLE_HI = 8'hDF;
   localparam logic [15:0] BANK_WIN_LO = 16'h8000;
   localparam logic [15:0] BANK_WIN_HI = 16'hBFFF;
   localparam logic [15:0] HSRAM_LO_DEF = 16'hFE20;
   localparam logic [15:0] HSRAM_HI_DEF = 16'hFEFF;
   localparam logic [2:0] PAGE_RESET = 3'h0;
   localparam logic [7:0] OPC_LOAD_A_SECOND = 8'h85;
   // ------------------------------------------------------------
   // Addressing modes and implied operations
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      MODE_JUMP_ACC, MODE_IMPLIED, MODE_REG8, MODE_REG16, MODE_DIRECT,
      MODE_SHORT, MODE_SFR, MODE_IND_SECOND, MODE_IND_BASE, MODE_BASED,
      MODE_IDX_B, MODE_IDX_C, MODE_STACK
   } cpuag_mode_type;
   typedef enum logic [1:0] {
      IMP_MULTIPLY, IMP_DIVIDE, IMP_ADJUST, IMP_ROTATE
   } cpuag_implied_type;
endpackage
`default_nettype wire

// file: rtl/cpuag_addr_gen.sv
// Address generation unit with general register bank and memory page select
// Summary of operation
// [RULE_01] Jump via accumulator pair loads program counter with that pair.
// [RULE_02] Multiply implicitly reads accumulator byte, writes accumulator pair.
// [RULE_03] Word divide implicitly reads and writes the accumulator pair.
// [RULE_04] Decimal adjust add and subtract implicitly use the accumulator byte.
// [RULE_05] Digit rotate left and right implicitly use the accumulator byte.
// [RULE_06] Implied operations need no operand field; accumulator chosen automatically.
// [RULE_07] Register operand index is bank select flags joined to register code.
// [RULE_08] Bytes 0-7 are X,A,C,B,E,D,L,H; pairs 0-3 accumulator,BC,second,base.
// [RULE_09] Direct mode uses the 16-bit immediate as the address.
// [RULE_10] Short direct reaches the window FE20H to FF1FH by an 8-bit immediate.
// [RULE_11] Short direct bit 8 is 1 for immediates below 20H, else 0.
// [RULE_12] Word short direct operands must sit at even addresses.
// [RULE_13] Special register mode reaches FF00H-FFCFH and FFE0H-FFFFH only.
// [RULE_14] Word special register accesses must sit at even addresses.
// [RULE_15] Register indirect uses second or base pair of the selected bank.
// [RULE_16] Based mode adds zero-extended offset to base pair, carry dropped.
// [RULE_17] Indexed mode adds zero-extended B or C to base pair, carry dropped.
// [RULE_18] Stack mode addresses memory through the stack pointer.
// [RULE_19] Stack pointer must stay inside internal high-speed RAM.
// [RULE_20] Software rewrites page select before reaching another memory bank.
// [RULE_21] Opcode 85H is a load of accumulator byte through the second pair.
// [RULE_22] Page select register clears to zero on reset.
// [RULE_23] Selected bank appears at 8000H-BFFFH; common area always visible.
// [RULE_24] Special register address is FFh above the 8-bit immediate.
// [RULE_25] Short direct address bits 15 to 9 are all ones.
`default_nettype none
module cpuag_addr_gen #(
   parameter logic [15:0] HSRAM_LO = cpuag_pkg::HSRAM_LO_DEF,
   parameter logic [15:0] HSRAM_HI = cpuag_pkg::HSRAM_HI_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Request from the instruction decoder
   input wire logic ag_req,
   input wire cpuag_pkg::cpuag_mode_type ag_mode,
   input wire cpuag_pkg::cpuag_implied_type implied_op,
   input wire logic word_access,
   input wire logic opcode_valid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] imm8,
   input wire logic [15:0] imm16,
   input wire logic [2:0] byte_reg_code,
   input wire logic [1:0] pair_reg_code,
   input wire logic reg_bank_sel_lo,
   input wire logic reg_bank_sel_hi,
   input wire logic [15:0] stack_ptr,
   // Register bank write port from execution
   input wire logic rf_wr_en,
   input wire logic rf_wr_pair,
   input wire logic [4:0] rf_wr_index,
   input wire logic [15:0] rf_wr_data,
   // Memory page select write port
   input wire logic page_wr_en,
   input wire logic [2:0] page_wr_data,
   // Address results
   output logic ea_valid,
   output logic [15:0] eff_addr,
   output logic pc_load,
   output logic [15:0] pc_target,
   output logic [4:0] src_reg_index,
   output logic [4:0] dst_reg_index,
   output logic dst_is_pair,
   output logic load_acc_second,
   // Faults and memory bank view
   output logic align_fault,
   output logic sfr_hole_fault,
   output logic stack_fault,
   output logic [2:0] mem_page,
   output logic banked_access
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Index of a byte register within the four banks
   function automatic logic [4:0] byte_index(input logic [1:0] bank, input logic [2:0] code);
      byte_index = {bank, code};
   endfunction

   // Low byte index of a register pair
   function automatic logic [4:0] pair_index(input logic [1:0] bank, input logic [1:0] pn);
      pair_index = {bank, pn, 1'b0};
   endfunction

   logic [7:0] rf_reg [0:31];
   logic [7:0] rf_next [0:31];
   logic [2:0] page_reg, page_next;
   logic ea_valid_reg, ea_valid_next, pc_load_reg, pc_load_next;
   logic [15:0] ea_reg, ea_next, pc_reg, pc_next;
   logic [4:0] src_reg, src_next, dst_reg, dst_next;
   logic dpair_reg, dpair_next, lda_reg, lda_next;
   logic align_reg, align_next, hole_reg, hole_next, stk_reg, stk_next;
   logic [1:0] bank_sel;
   logic [15:0] acc_pair, second_pair, base_pair;
   logic [7:0] reg_b, reg_c;
   logic is_85;

   assign bank_sel = {reg_bank_sel_hi, reg_bank_sel_lo}; // RULE_07
   // Pair contents: high byte at odd index, low byte at even index
   assign acc_pair = {rf_reg[byte_index(bank_sel, cpuag_pkg::CODE_A)],
                      rf_reg[byte_index(bank_sel, cpuag_pkg::CODE_X)]}; // RULE_08
   assign second_pair = {rf_reg[byte_index(bank_sel, cpuag_pkg::CODE_D)],
                         rf_reg[byte_index(bank_sel, cpuag_pkg::CODE_E)]}; // RULE_15
   assign base_pair = {rf_reg[byte_index(bank_sel, cpuag_pkg::CODE_H)],
                       rf_reg[byte_index(bank_sel, cpuag_pkg::CODE_L)]}; // RULE_15
   assign reg_b = rf_reg[byte_index(bank_sel, cpuag_pkg::CODE_B)];
   assign reg_c = rf_reg[byte_index(bank_sel, cpuag_pkg::CODE_C)];
   assign is_85 = opcode_valid && (opcode == cpuag_pkg::OPC_LOAD_A_SECOND); // RULE_21

   // ------------------------------------------------------------
   // Register bank and page select
   // ------------------------------------------------------------
   // Byte or pair write into the register bank; page select write
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         rf_next[i] = rf_reg[i];
      end
      if (rf_wr_en) begin
         if (rf_wr_pair) begin
            rf_next[{rf_wr_index[4:1], 1'b0}] = rf_wr_data[7:0];
            rf_next[{rf_wr_index[4:1], 1'b1}] = rf_wr_data[15:8];
         end else begin
            rf_next[rf_wr_index] = rf_wr_data[7:0];
         end
      end
      page_next = page_wr_en ? page_wr_data : page_reg;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 32; i++) begin
            rf_reg[i] <= 8'h00;
         end
         page_reg <= cpuag_pkg::PAGE_RESET; // RULE_22
      end else begin
         for (int i = 0; i < 32; i++) begin
            rf_reg[i] <= rf_next[i];
         end
         page_reg <= page_next;
      end
   end

   // ------------------------------------------------------------
   // Address formation
   // ------------------------------------------------------------
   // One result per request, registered one cycle after it
   always_comb begin
      ea_valid_next = ag_req;
      pc_load_next = 1'b0;
      ea_next = ea_reg;
      pc_next = pc_reg;
      src_next = src_reg;
      dst_next = dst_reg;
      dpair_next = dpair_reg;
      lda_next = 1'b0;
      align_next = 1'b0;
      hole_next = 1'b0;
      stk_next = 1'b0;
      if (ag_req && is_85) begin
         ea_next = second_pair; // RULE_21
         dst_next = byte_index(bank_sel, cpuag_pkg::CODE_A);
         dpair_next = 1'b0;
         lda_next = 1'b1;
      end else if (ag_req) begin
         unique case (ag_mode)
            cpuag_pkg::MODE_JUMP_ACC: begin
               pc_load_next = 1'b1; // RULE_01
               pc_next = acc_pair;
            end
            cpuag_pkg::MODE_IMPLIED: begin
               // No operand field: accumulator indices are built here
               src_next = byte_index(bank_sel, cpuag_pkg::CODE_A); // RULE_06
               dst_next = pair_index(bank_sel, cpuag_pkg::PAIR_ACC);
               dpair_next = 1'b1;
               unique case (implied_op)
                  cpuag_pkg::IMP_MULTIPLY: begin
                     src_next = byte_index(bank_sel, cpuag_pkg::CODE_A); // RULE_02
                  end
                  cpuag_pkg::IMP_DIVIDE: begin
                     src_next = pair_index(bank_sel, cpuag_pkg::PAIR_ACC); // RULE_03
                  end
                  cpuag_pkg::IMP_ADJUST, cpuag_pkg::IMP_ROTATE: begin
                     dst_next = byte_index(bank_sel, cpuag_pkg::CODE_A); // RULE_04 RULE_05
                     dpair_next = 1'b0;
                  end
               endcase
            end
            cpuag_pkg::MODE_REG8: begin
               dst_next = byte_index(bank_sel, byte_reg_code); // RULE_07
               dpair_next = 1'b0;
            end
            cpuag_pkg::MODE_REG16: begin
               dst_next = pair_index(bank_sel, pair_reg_code); // RULE_08
               dpair_next = 1'b1;
            end
            cpuag_pkg::MODE_DIRECT: begin
               ea_next = imm16; // RULE_09
            end
            cpuag_pkg::MODE_SHORT: begin
               ea_next = {cpuag_pkg::SHORT_TOP_BITS, imm8 < cpuag_pkg::SHORT_SPLIT, imm8}; // RULE_10 RULE_11 RULE_25
               align_next = word_access && imm8[0]; // RULE_12
            end
            cpuag_pkg::MODE_SFR: begin
               ea_next = {cpuag_pkg::SFR_PAGE, imm8}; // RULE_24
               hole_next = (imm8 >= cpuag_pkg::SFR_HOLE_LO) && (imm8 <= cpuag_pkg::SFR_HOLE_HI); // RULE_13
               align_next = word_access && imm8[0]; // RULE_14
            end
            cpuag_pkg::MODE_IND_SECOND: begin
               ea_next = second_pair; // RULE_15
            end
            cpuag_pkg::MODE_IND_BASE: begin
               ea_next = base_pair; // RULE_15
            end
            cpuag_pkg::MODE_BASED: begin
               ea_next = base_pair + {8'h00, imm8}; // RULE_16
            end
            cpuag_pkg::MODE_IDX_B: begin
               ea_next = base_pair + {8'h00, reg_b}; // RULE_17
            end
            cpuag_pkg::MODE_IDX_C: begin
               ea_next = base_pair + {8'h00, reg_c}; // RULE_17
            end
            cpuag_pkg::MODE_STACK: begin
               ea_next = stack_ptr; // RULE_18
               stk_next = (stack_ptr < HSRAM_LO) || (stack_ptr > HSRAM_HI); // RULE_19
            end
            default: begin
               ea_valid_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ea_valid_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         ea_reg <= 16'h0000;
         pc_reg <= 16'h0000;
         src_reg <= 5'h00;
         dst_reg <= 5'h00;
         dpair_reg <= 1'b0;
         lda_reg <= 1'b0;
         align_reg <= 1'b0;
         hole_reg <= 1'b0;
         stk_reg <= 1'b0;
      end else begin
         ea_valid_reg <= ea_valid_next;
         pc_load_reg <= pc_load_next;
         ea_reg <= ea_next;
         pc_reg <= pc_next;
         src_reg <= src_next;
         dst_reg <= dst_next;
         dpair_reg <= dpair_next;
         lda_reg <= lda_next;
         align_reg <= align_next;
         hole_reg <= hole_next;
         stk_reg <= stk_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Bank view: the page only applies inside the banked window
   assign banked_access = (ea_reg >= cpuag_pkg::BANK_WIN_LO) && (ea_reg <= cpuag_pkg::BANK_WIN_HI); // RULE_23
   assign mem_page = page_reg; // RULE_20
   assign ea_valid = ea_valid_reg;
   assign eff_addr = ea_reg;
   assign pc_load = pc_load_reg;
   assign pc_target = pc_reg;
   assign src_reg_index = src_reg;
   assign dst_reg_index = dst_reg;
   assign dst_is_pair = dpair_reg;
   assign load_acc_second = lda_reg;
   assign align_fault = align_reg;
   assign sfr_hole_fault = hole_reg;
   assign stack_fault = stk_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence seq_req(cpuag_pkg::cpuag_mode_type m);
      ag_req && !is_85 && (ag_mode == m);
   endsequence

   chk_jump_target: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
      seq_req(cpuag_pkg::MODE_JUMP_ACC) |=> pc_load && (pc_target == $past(acc_pair))
      ##1 (pc_load == $past(ag_req && !is_85 && (ag_mode == cpuag_pkg::MODE_JUMP_ACC))))
      else $error("jump target not taken from accumulator pair");
   chk_implied_acc: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
      seq_req(cpuag_pkg::MODE_IMPLIED) ##0 (implied_op == cpuag_pkg::IMP_MULTIPLY)
      |=> (src_reg_index[2:0] == cpuag_pkg::CODE_A) && dst_is_pair && (dst_reg_index[2:0] == 3'h0))
      else $error("multiply operands not the accumulator");
   chk_reg_index: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
      seq_req(cpuag_pkg::MODE_REG8) |=> dst_reg_index == {$past(bank_sel), $past(byte_reg_code)})
      else $error("register index wrong");
   chk_direct_addr: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
      seq_req(cpuag_pkg::MODE_DIRECT) |=> ea_valid && (eff_addr == $past(imm16)))
      else $error("direct address wrong");
   chk_short_window: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
      seq_req(cpuag_pkg::MODE_SHORT) |=> (eff_addr >= 16'hFE20) && (eff_addr <= 16'hFF1F)
      && (eff_addr[8] == ($past(imm8) < 8'h20)) && (eff_addr[7:0] == $past(imm8)))
      else $error("short direct address outside window");
   chk_sfr_addr: assert property (@(posedge clk) disable iff (!rstn) // RULE_24
      seq_req(cpuag_pkg::MODE_SFR) |=> (eff_addr == {8'hFF, $past(imm8)})
      && (sfr_hole_fault == ($past(imm8[7:4]) == 4'hD)))
      else $error("special register address wrong");
   chk_word_align: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
      (seq_req(cpuag_pkg::MODE_SHORT) or seq_req(cpuag_pkg::MODE_SFR)) |=>
      align_fault == ($past(word_access) && eff_addr[0]))
      else $error("odd word address not flagged");
   chk_based_sum: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
      seq_req(cpuag_pkg::MODE_BASED) |=> eff_addr == 16'($past(base_pair) + {8'h00, $past(imm8)}))
      else $error("based address wrong");
   chk_stack_range: assert property (@(posedge clk) disable iff (!rstn) // RULE_19
      seq_req(cpuag_pkg::MODE_STACK) |=> (eff_addr == $past(stack_ptr))
      && (stack_fault == ((eff_addr < HSRAM_LO) || (eff_addr > HSRAM_HI))))
      else $error("stack address or fault wrong");
   chk_load_decode: assert property (@(posedge clk) disable iff (!rstn) // RULE_21
      (ag_req && is_85) |=> load_acc_second && (eff_addr == $past(second_pair))
      ##1 (load_acc_second == $past(ag_req && is_85)))
      else $error("opcode 85 not decoded as load through second pair");
   chk_page_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE_20
      !page_wr_en |=> $stable(mem_page))
      else $error("page select changed without a write");
endmodule
`default_nettype wire

// file: verification/cpuag_mem_model.sv
// Far-side memory model that watches operand accesses and the banked view
`default_nettype none
module cpuag_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Access from the address generator
   input wire logic ea_valid,
   input wire logic [15:0] eff_addr,
   input wire logic banked_access,
   // Observation
   output logic [7:0] bank_err_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // Count accesses whose banked indication disagrees with the window
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bank_err_count <= 8'h00;
      end else if (ea_valid && (banked_access !== (eff_addr >= 16'h8000 && eff_addr <= 16'hBFFF))) begin
         bank_err_count <= bank_err_count + 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: verification/test_cpu_address_generation.sv
// Self-checking testbench for the CPU address generation block
`default_nettype none
module test_cpu_address_generation;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic clk, rstn, ag_req, word_access, opcode_valid, reg_bank_sel_lo, reg_bank_sel_hi;
   logic rf_wr_en, rf_wr_pair, page_wr_en;
   cpuag_pkg::cpuag_mode_type ag_mode;
   cpuag_pkg::cpuag_implied_type implied_op;
   logic [7:0] opcode, imm8, bank_err_count;
   logic [15:0] imm16, stack_ptr, rf_wr_data, eff_addr, pc_target;
   logic [2:0] byte_reg_code, page_wr_data, mem_page;
   logic [1:0] pair_reg_code;
   logic [4:0] rf_wr_index, src_reg_index, dst_reg_index;
   logic ea_valid, pc_load, dst_is_pair, load_acc_second, align_fault, sfr_hole_fault, stack_fault, banked_access;
   int fail_count = 0;
   int checks_done = 0;
   // Design and far-side model
   cpuag_addr_gen dut_u (.clk(clk), .rstn(rstn), .ag_req(ag_req), .ag_mode(ag_mode), .implied_op(implied_op),
      .word_access(word_access), .opcode_valid(opcode_valid), .opcode(opcode), .imm8(imm8), .imm16(imm16),
      .byte_reg_code(byte_reg_code), .pair_reg_code(pair_reg_code), .reg_bank_sel_lo(reg_bank_sel_lo),
      .reg_bank_sel_hi(reg_bank_sel_hi), .stack_ptr(stack_ptr), .rf_wr_en(rf_wr_en), .rf_wr_pair(rf_wr_pair),
      .rf_wr_index(rf_wr_index), .rf_wr_data(rf_wr_data), .page_wr_en(page_wr_en), .page_wr_data(page_wr_data),
      .ea_valid(ea_valid), .eff_addr(eff_addr), .pc_load(pc_load), .pc_target(pc_target),
      .src_reg_index(src_reg_index), .dst_reg_index(dst_reg_index), .dst_is_pair(dst_is_pair),
      .load_acc_second(load_acc_second), .align_fault(align_fault), .sfr_hole_fault(sfr_hole_fault),
      .stack_fault(stack_fault), .mem_page(mem_page), .banked_access(banked_access));
   cpuag_mem_model mem_u (.clk(clk), .rstn(rstn), .ea_valid(ea_valid), .eff_addr(eff_addr),
      .banked_access(banked_access), .bank_err_count(bank_err_count));
   // Clock generator
   always #20 clk = ~clk;
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Compare one value and count the result
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One address request, held for one edge, answer taken the edge after
   task automatic req(input cpuag_pkg::cpuag_mode_type m, input logic [7:0] i8, input logic [15:0] i16,
      input logic w);
      @(posedge clk);
      #1;
      ag_req = 1'b1;
      ag_mode = m;
      imm8 = i8;
      imm16 = i16;
      word_access = w;
      @(posedge clk);
      #1;
      ag_req = 1'b0;
      opcode_valid = 1'b0;
      chk({15'h0000, ea_valid}, 16'h0001);
   endtask
   // Register bank write, byte or pair
   task automatic wr(input logic pair, input logic [4:0] idx, input logic [15:0] d);
      @(posedge clk);
      #1;
      rf_wr_en = 1'b1;
      rf_wr_pair = pair;
      rf_wr_index = idx;
      rf_wr_data = d;
      @(posedge clk);
      #1;
      rf_wr_en = 1'b0;
   endtask
   // Select a register bank by its two flags
   task automatic bank(input logic [1:0] b);
      reg_bank_sel_hi = b[1];
      reg_bank_sel_lo = b[0];
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Jump through accumulator pair, pulses last one cycle
   task automatic t_jump();
      bank(2'h2);
      wr(1'b1, {2'h2, cpuag_pkg::PAIR_ACC, 1'b0}, 16'hA55A);
      req(cpuag_pkg::MODE_JUMP_ACC, 8'h00, 16'h0000, 1'b0);
      chk({15'h0000, pc_load}, 16'h0001);
      chk(pc_target, 16'hA55A);
      @(posedge clk);
      #1;
      chk({14'h0000, pc_load, ea_valid}, 16'h0000);
   endtask
   // Pointer pairs of two banks, opcode override, based and indexed sums with and without carry
   task automatic t_pointers();
      wr(1'b1, {2'h3, cpuag_pkg::PAIR_SECOND, 1'b0}, 16'h8123);
      wr(1'b1, {2'h3, cpuag_pkg::PAIR_BASE, 1'b0}, 16'hFFF8);
      wr(1'b1, {2'h0, cpuag_pkg::PAIR_SECOND, 1'b0}, 16'h1111);
      wr(1'b0, {2'h3, cpuag_pkg::CODE_B}, 16'h00F0);
      wr(1'b0, {2'h3, cpuag_pkg::CODE_C}, 16'h0007);
      bank(2'h0);
      req(cpuag_pkg::MODE_IND_SECOND, 8'h00, 16'h0000, 1'b0);
      chk(eff_addr, 16'h1111);
      bank(2'h3);
      req(cpuag_pkg::MODE_IND_SECOND, 8'h00, 16'h0000, 1'b0);
      chk(eff_addr, 16'h8123);
      req(cpuag_pkg::MODE_IND_BASE, 8'h00, 16'h0000, 1'b0);
      chk(eff_addr, 16'hFFF8);
      opcode_valid = 1'b1;
      opcode = 8'h85;
      stack_ptr = 16'hFE40;
      req(cpuag_pkg::MODE_STACK, 8'h00, 16'h0000, 1'b0);
      chk({15'h0000, load_acc_second}, 16'h0001);
      chk(eff_addr, 16'h8123);
      req(cpuag_pkg::MODE_BASED, 8'h10, 16'h0000, 1'b0);
      chk(eff_addr, 16'h0008);
      req(cpuag_pkg::MODE_IDX_B, 8'h00, 16'h0000, 1'b0);
      chk(eff_addr, 16'h00E8);
      req(cpuag_pkg::MODE_IDX_C, 8'h00, 16'h0000, 1'b0);
      chk(eff_addr, 16'hFFFF);
   endtask
   // Page select, then direct addresses around the banked window
   task automatic t_direct();
      logic [15:0] a [4] = '{16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000};
      @(posedge clk);
      #1;
      page_wr_en = 1'b1;
      page_wr_data = 3'h3;
      @(posedge clk);
      #1;
      page_wr_en = 1'b0;
      chk({13'h0000, mem_page}, 16'h0003);
      for (int k = 0; k < 4; k++) begin
         req(cpuag_pkg::MODE_DIRECT, 8'h00, a[k], 1'b0);
         chk(eff_addr, a[k]);
         chk({15'h0000, banked_access}, {15'h0000, k == 1 || k == 2});
      end
   endtask
   // Mid-run reset clears the page select and the pulses
   task automatic t_reset();
      chk({8'h00, bank_err_count}, 16'h0000);
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk({13'h0000, mem_page}, 16'h0000);
      chk({15'h0000, ea_valid}, 16'h0000);
   endtask
   // Short direct window edges and word alignment
   task automatic t_short();
      logic [7:0] v [6] = '{8'h00, 8'h1F, 8'h20, 8'hFF, 8'h21, 8'h22};
      logic [15:0] e [6] = '{16'hFF00, 16'hFF1F, 16'hFE20, 16'hFEFF, 16'hFE21, 16'hFE22};
      for (int k = 0; k < 6; k++) begin
         req(cpuag_pkg::MODE_SHORT, v[k], 16'h0000, k >= 4);
         chk(eff_addr, e[k]);
         chk({15'h0000, align_fault}, {15'h0000, k == 4});
      end
   endtask
   // Special register page, hole edges and word alignment
   task automatic t_sfr();
      logic [7:0] v [7] = '{8'h00, 8'hCF, 8'hD0, 8'hDF, 8'hE0, 8'hFF, 8'h01};
      for (int k = 0; k < 7; k++) begin
         req(cpuag_pkg::MODE_SFR, v[k], 16'h0000, k == 6);
         chk(eff_addr, {8'hFF, v[k]});
         chk({15'h0000, sfr_hole_fault}, {15'h0000, k == 2 || k == 3});
         chk({15'h0000, align_fault}, {15'h0000, k == 6});
      end
   endtask
   // Stack pointer inside and just outside the fast RAM
   task automatic t_stack();
      logic [15:0] s [4] = '{16'hFE20, 16'hFEFF, 16'hFE1F, 16'hFF00};
      for (int k = 0; k < 4; k++) begin
         stack_ptr = s[k];
         req(cpuag_pkg::MODE_STACK, 8'h00, 16'h0000, 1'b0);
         chk(eff_addr, s[k]);
         chk({15'h0000, stack_fault}, {15'h0000, k >= 2});
      end
   endtask
   // Implied operations pick accumulator registers of the current bank
   task automatic t_implied();
      bank(2'h1);
      for (int k = 0; k < 4; k++) begin
         implied_op = cpuag_pkg::cpuag_implied_type'(k[1:0]);
         req(cpuag_pkg::MODE_IMPLIED, 8'h00, 16'h0000, 1'b0);
         chk({15'h0000, dst_is_pair}, {15'h0000, k < 2});
         if (k < 2) begin
            chk({12'h000, dst_reg_index[4:1]}, 16'h0004);
         end else begin
            chk({11'h000, dst_reg_index}, 16'h0009);
         end
         if (k != 1) begin
            chk({11'h000, src_reg_index}, 16'h0009);
         end else begin
            chk({11'h000, src_reg_index}, 16'h0008);
         end
      end
   endtask
   // Register fields joined to the bank flags
   task automatic t_regs();
      bank(2'h2);
      for (int k = 0; k < 8; k++) begin
         byte_reg_code = k[2:0];
         req(cpuag_pkg::MODE_REG8, 8'h00, 16'h0000, 1'b0);
         chk({10'h000, dst_is_pair, dst_reg_index}, {11'h000, 2'h2, k[2:0]});
      end
      for (int k = 0; k < 4; k++) begin
         pair_reg_code = k[1:0];
         req(cpuag_pkg::MODE_REG16, 8'h00, 16'h0000, 1'b0);
         chk({11'h000, dst_is_pair, dst_reg_index[4:1]}, {11'h000, 1'b1, 2'h2, k[1:0]});
      end
   endtask
   // ------------------------------------------------------------
   // Verdict and run control
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog well beyond the 125 or so cycles the tests need
   initial begin
      #(40 * 3000);
      fail_count++;
      complete_run();
   end
   // Main sequence
   initial begin
      {clk, rstn, ag_req, word_access, opcode_valid, reg_bank_sel_lo, reg_bank_sel_hi} = 7'h00;
      {rf_wr_en, rf_wr_pair, page_wr_en, opcode, imm8, imm16, stack_ptr} = '0;
      {byte_reg_code, pair_reg_code, rf_wr_index, rf_wr_data, page_wr_data} = '0;
      ag_mode = cpuag_pkg::MODE_JUMP_ACC;
      implied_op = cpuag_pkg::IMP_MULTIPLY;
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk({13'h0000, mem_page}, 16'h0000);
      chk({15'h0000, ea_valid}, 16'h0000);
      t_jump();
      t_pointers();
      t_direct();
      t_reset();
      t_short();
      t_sfr();
      t_stack();
      t_implied();
      t_regs();
      chk({8'h00, bank_err_count}, 16'h0000);
      complete_run();
   end
endmodule
`default_nettype wire
